// *** hw/bwrc_ctrl.v ***
// Host controller that reads and writes a 256 x 1 asynchronous static RAM
//
// How it works
// [RULE_01] Eight address bits pick one of 256
// [RULE_02] All three selects low to select device
// [RULE_03] Sample read data after address access time
// [RULE_04] Select also settles before read sampling
// [RULE_05] Write shows inverse of data bit
// [RULE_06] Inverse checked after strobe-to-inverse delay
// [RULE_07] Deselect then wait for output off
// [RULE_08] Strobe low at least 25 ns
// [RULE_09] Address stable across whole strobe
// [RULE_10] Data stable 25 ns before strobe rise
// [RULE_11] Selects held low around strobe
// [RULE_12] Contents untouched by reads and idle
`timescale 1ns/10ps
`include "bwrc_map.vh"

module bwrc_ctrl (
	input wire core_clk,
	input wire rstn,
	input wire req_valid,
	output wire req_ready,
	input wire req_write,
	input wire [`BWRC_ADDR_W-1:0] req_addr,
	input wire req_data,
	output reg rsp_valid,
	output reg rsp_data,
	output reg rsp_error,
	output reg [`BWRC_ADDR_W-1:0] mem_addr,
	output reg mem_din,
	output reg [2:0] mem_sel_n,
	output reg mem_wr_n,
	input wire mem_dout
);

	// ********************
	// States and counts
	// ********************
	localparam ST_IDLE = 3'd0;
	localparam ST_SETUP = 3'd1;
	localparam ST_READ = 3'd2;
	localparam ST_WRITE = 3'd3;
	localparam ST_HOLD = 3'd4;
	localparam ST_OFF = 3'd5;
	localparam [31:0] READ_CYC_W = `BWRC_READ_CYC;
	localparam [31:0] WRITE_CYC_W = `BWRC_WRITE_CYC;
	localparam [31:0] OFF_CYC_W = `BWRC_OFF_CYC;
	localparam [31:0] VERIFY_CYC_W = `BWRC_VERIFY_CYC;
	// Counts fit eight bits at this clock
	localparam [7:0] READ_CYC = READ_CYC_W[7:0];
	localparam [7:0] WRITE_CYC = WRITE_CYC_W[7:0];
	localparam [7:0] OFF_CYC = OFF_CYC_W[7:0];
	localparam [7:0] VERIFY_CYC = VERIFY_CYC_W[7:0];
	// Strobe held long enough for both store and echo
	localparam [7:0] LOW_CYC = (WRITE_CYC > VERIFY_CYC) ? WRITE_CYC : VERIFY_CYC;

	// ********************
	// Registers
	// ********************
	reg [2:0] state_q;
	reg [2:0] state_d;
	reg [7:0] cnt_q;
	reg [7:0] cnt_d;
	reg sel_on_q;
	reg sel_on_d;
	reg [`BWRC_ADDR_W-1:0] addr_d;
	reg din_d;
	reg wr_n_d;
	reg rsp_valid_d;
	reg rsp_data_d;
	reg rsp_error_d;
	wire [2:0] sel_n_d;
	genvar gi;

	// ********************
	// Waits
	// ********************
	// Shared end-of-wait decode for every timed state
	function cnt_done;
		input [7:0] cnt;
		input [7:0] limit;
		begin
			cnt_done = (cnt >= limit - 8'h01);
		end
	endfunction

	// ********************
	// Handshake
	// ********************
	assign req_ready = (state_q == ST_IDLE);

	// ********************
	// Select fan-out
	// ********************
	// Selects move as one, so no partial select is ever seen
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_sel
			assign sel_n_d[gi] = ~sel_on_d;
		end
	endgenerate

	// ********************
	// Sequencer
	// ********************
	always @* begin
		state_d = state_q;
		cnt_d = cnt_q;
		sel_on_d = sel_on_q;
		addr_d = mem_addr;
		din_d = mem_din;
		wr_n_d = mem_wr_n;
		rsp_valid_d = 1'b0;
		rsp_data_d = rsp_data;
		rsp_error_d = rsp_error;
		case (state_q)
		ST_IDLE: begin
			if (req_valid) begin
				// [RULE_01] full binary address
				addr_d = req_addr;
				din_d = req_data;
				// [RULE_02] all selects low together
				sel_on_d = 1'b1;
				cnt_d = 8'h00;
				if (req_write) begin
					state_d = ST_SETUP;
				end else begin
					state_d = ST_READ;
				end
			end
		end
		ST_SETUP: begin
			// [RULE_09] address settled before strobe falls
			// [RULE_11] selects already low
			wr_n_d = 1'b0;
			cnt_d = 8'h00;
			state_d = ST_WRITE;
		end
		ST_READ: begin
			// [RULE_12] strobe stays high on reads
			wr_n_d = `BWRC_STROBE_OFF;
			// [RULE_03] wait address access time
			// [RULE_04] covers shorter select access too
			if (cnt_done(cnt_q, READ_CYC)) begin
				rsp_data_d = mem_dout;
				rsp_error_d = 1'b0;
				rsp_valid_d = 1'b1;
				// [RULE_07] release selects, output turns off
				sel_on_d = 1'b0;
				cnt_d = 8'h00;
				state_d = ST_OFF;
			end else begin
				cnt_d = cnt_q + 8'h01;
			end
		end
		ST_WRITE: begin
			// [RULE_08] strobe low for full width
			// [RULE_10] data held since strobe fell
			if (cnt_done(cnt_q, LOW_CYC)) begin
				// [RULE_05] echo must be inverse of data
				// [RULE_06] sampled after strobe-to-inverse delay
				rsp_data_d = mem_dout;
				rsp_error_d = (mem_dout == mem_din);
				wr_n_d = 1'b1;
				cnt_d = 8'h00;
				state_d = ST_HOLD;
			end else begin
				cnt_d = cnt_q + 8'h01;
			end
		end
		ST_HOLD: begin
			// [RULE_11] selects released after strobe rose
			sel_on_d = 1'b0;
			rsp_valid_d = 1'b1;
			cnt_d = 8'h00;
			state_d = ST_OFF;
		end
		ST_OFF: begin
			// [RULE_07] output off before next cycle
			if (cnt_done(cnt_q, OFF_CYC)) begin
				state_d = ST_IDLE;
			end else begin
				cnt_d = cnt_q + 8'h01;
			end
		end
		default: begin
			state_d = ST_IDLE;
			sel_on_d = 1'b0;
			wr_n_d = `BWRC_STROBE_OFF;
		end
		endcase
	end

	// ********************
	// Pin launch
	// ********************
	// Every pin leaves a flop, so the device never sees a glitch
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= ST_IDLE;
			cnt_q <= 8'h00;
			sel_on_q <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= 1'b0;
			rsp_error <= 1'b0;
			mem_addr <= `BWRC_ADDR_RST;
			mem_din <= 1'b0;
			mem_sel_n <= `BWRC_SEL_OFF;
			mem_wr_n <= `BWRC_STROBE_OFF;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			sel_on_q <= sel_on_d;
			rsp_valid <= rsp_valid_d;
			rsp_data <= rsp_data_d;
			rsp_error <= rsp_error_d;
			mem_addr <= addr_d;
			mem_din <= din_d;
			mem_sel_n <= sel_n_d;
			mem_wr_n <= wr_n_d;
		end
	end

endmodule

// *** inc/bwrc_map.vh ***
// Pin timing constants for the bit-wide RAM controller
`ifndef BWRC_MAP_VH
`define BWRC_MAP_VH

// Clock period in picoseconds (250 MHz)
`define BWRC_CLK_PS 4000
// Memory geometry
`define BWRC_ADDR_W 8
`define BWRC_WORDS 256
// Device timing in nanoseconds, as printed
`define BWRC_ADDR_TO_OUTPUT_DELAY_NS 40
`define BWRC_SELECT_TO_OUTPUT_DELAY_NS 25
`define BWRC_DESELECT_TO_OFF_DELAY_NS 25
`define BWRC_STROBE_TO_INVERSE_DELAY_NS 40
`define BWRC_STROBE_LOW_WIDTH_NS 25
`define BWRC_DATA_SETUP_NS 25
// Pin levels after reset; selects and strobe also rest at these while idle
`define BWRC_SEL_OFF 3'h7
`define BWRC_STROBE_OFF 1'b1
`define BWRC_ADDR_RST 8'h00
// Least waits round up to whole cycles
`define BWRC_CYC(ns) (((ns) * 1000 + `BWRC_CLK_PS - 1) / `BWRC_CLK_PS)
`define BWRC_READ_CYC `BWRC_CYC(`BWRC_ADDR_TO_OUTPUT_DELAY_NS)
`define BWRC_WRITE_CYC `BWRC_CYC(`BWRC_STROBE_LOW_WIDTH_NS)
`define BWRC_OFF_CYC `BWRC_CYC(`BWRC_DESELECT_TO_OFF_DELAY_NS)
`define BWRC_VERIFY_CYC `BWRC_CYC(`BWRC_STROBE_TO_INVERSE_DELAY_NS)

`endif

// *** testbench/bwrc_ram_model.sv ***
// Model of a 256 x 1 RAM
`timescale 1ns/10ps
module bwrc_ram_model #(
	parameter int ADDR_DLY = 39,
	parameter int SEL_DLY = 24,
	parameter int INV_DLY = 39
) (
	input wire logic [7:0] mem_addr,
	input wire logic mem_din,
	input wire logic [2:0] mem_sel_n,
	input wire logic mem_wr_n,
	output wire logic mem_dout
);
	// Each path just inside its limit, so short waits read stale data
	logic mem [256];
	wire sel;
	wire rd_bit;
	wire sel_seen;
	wire wr_seen;
	assign sel = mem_sel_n == 3'h0;
	always @* if (sel && !mem_wr_n) mem[mem_addr] = mem_din;
	assign #(ADDR_DLY) rd_bit = mem[mem_addr];
	assign #(SEL_DLY) sel_seen = sel;
	assign #(INV_DLY) wr_seen = sel && !mem_wr_n;
	// inverse while writing, off reads 1
	assign mem_dout = !sel_seen ? 1'b1 : wr_seen ? !mem_din : rd_bit;
endmodule

// *** testbench/bwrc_ctrl_sva.sv ***
// Strobe, select and off-wait checks
`timescale 1ns/10ps
module bwrc_ctrl_sva (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic req_ready,
	input wire logic [7:0] mem_addr,
	input wire logic mem_din,
	input wire logic [2:0] mem_sel_n,
	input wire logic mem_wr_n
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sequence s_fall; $fell(mem_wr_n); endsequence
	sequence s_sel_on; $fell(mem_sel_n[0]); endsequence
	sequence s_sel_off; $rose(mem_sel_n[0]); endsequence
	property p_w; s_fall |-> !mem_wr_n [*7]; endproperty
	a_w: assert property (p_w) else $error("short");
	property p_a; !mem_wr_n |-> $stable(mem_addr); endproperty
	a_a: assert property (p_a) else $error("addr");
	property p_d; !mem_wr_n |-> $stable(mem_din); endproperty
	a_d: assert property (p_d) else $error("data");
	property p_s; !mem_wr_n |-> mem_sel_n == 3'h0; endproperty
	a_s: assert property (p_s) else $error("sel");
	property p_h; $rose(mem_wr_n) |-> mem_sel_n == 3'h0; endproperty
	a_h: assert property (p_h) else $error("sel hold");
	property p_g; (mem_sel_n == 3'h0) || (mem_sel_n == 3'h7); endproperty
	a_g: assert property (p_g) else $error("sel split");
	property p_r; s_sel_on |-> (mem_sel_n == 3'h0) [*8]; endproperty
	a_r: assert property (p_r) else $error("access");
	property p_o; s_sel_off |-> !req_ready [*7]; endproperty
	a_o: assert property (p_o) else $error("off wait");
endmodule
bind bwrc_ctrl bwrc_ctrl_sva chk (
	.core_clk(core_clk),
	.rstn(rstn),
	.req_ready(req_ready),
	.mem_addr(mem_addr),
	.mem_din(mem_din),
	.mem_sel_n(mem_sel_n),
	.mem_wr_n(mem_wr_n)
);

// *** testbench/tb_bwrc_ctrl.sv ***
// Bench for the RAM controller
`timescale 1ns/10ps
module tb_bwrc_ctrl;
	logic core_clk = 0, rstn = 0, req_valid = 0, req_write = 0, req_data = 0;
	logic [7:0] req_addr = 8'h00;
	wire req_ready, rsp_valid, rsp_data, rsp_error, mem_din, mem_wr_n, mem_dout;
	wire [7:0] mem_addr;
	wire [2:0] mem_sel_n;
	int errors = 0, num_checks = 0;
	always #2 core_clk = ~core_clk;
	bwrc_ctrl dut (
		.core_clk(core_clk),
		.rstn(rstn),
		.req_valid(req_valid),
		.req_ready(req_ready),
		.req_write(req_write),
		.req_addr(req_addr),
		.req_data(req_data),
		.rsp_valid(rsp_valid),
		.rsp_data(rsp_data),
		.rsp_error(rsp_error),
		.mem_addr(mem_addr),
		.mem_din(mem_din),
		.mem_sel_n(mem_sel_n),
		.mem_wr_n(mem_wr_n),
		.mem_dout(mem_dout)
	);
	bwrc_ram_model ram (
		.mem_addr(mem_addr),
		.mem_din(mem_din),
		.mem_sel_n(mem_sel_n),
		.mem_wr_n(mem_wr_n),
		.mem_dout(mem_dout)
	);
	task chk(string n, logic s, logic e);
		num_checks++;
		if (s !== e)
			errors++;
		if (s !== e)
			$display("wrong value %s exp %b seen %b", n, e, s);
	endtask
	task op(logic w, logic [7:0] a, logic d, logic e);
		{req_write, req_addr, req_data, req_valid} = {w, a, d, 1'b1};
		@(posedge core_clk) #1 req_valid = 0;
		repeat (30) if (rsp_valid !== 1'b1) @(posedge core_clk) #1;
		chk("rsp_valid", rsp_valid, 1);
		chk("rsp_data", rsp_data, e);
		chk("rsp_error", rsp_error, 1'b0);
		repeat (30) if (req_ready !== 1'b1) @(posedge core_clk) #1;
	endtask
	task t_rw;
		op(1, 8'hff, 1, 0);
		op(1, 8'h00, 0, 1);
		op(0, 8'hff, 0, 1);
		op(0, 8'h00, 1, 0);
		$display("rw done");
	endtask
	task t_walk;
		for (int i = 0; i < 8; i++)
			op(1'b1, 8'h01 << i, i[0], !i[0]);
		for (int i = 0; i < 8; i++)
			op(1'b0, 8'h01 << i, 1'b0, i[0]);
		op(1'b0, 8'hff, 1'b0, 1'b1);
		op(1'b0, 8'h00, 1'b0, 1'b0);
		$display("walk done");
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge core_clk);
		#1 rstn = 1;
		t_rw;
		t_walk;
		tally_and_finish;
	end
	initial begin
		#8000 errors++;
		tally_and_finish;
	end
endmodule
